/* File: src/dsc_slave.sv */
// Serial command slave front end of a bistable display module
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Serial input bits are ignored while chip select is high.
// - Serial output is released whenever chip select is high.
// - Input sampled on clock falling edge, output changed on rising edge.
// - Select falling starts a packet; first byte is command, then arguments.
// - Bytes travel most significant bit first in both directions.
// - One output byte per input byte; byte 0 goes with the command.
// - Reset pin low aborts and holds; release runs reset then sleeps.
// - Busy is high while a command runs and during the reset sequence.
// - Busy after a command drops only once select has risen; reset ends freely; ready when busy falls.
// - Status byte returned with every byte; top bit is busy.
// - Cleared busy bit appears three status bytes after completion.
// - Writing image memory never updates the panel; only update commands.
// - Update commands carry a start address anywhere in image memory.
// - Sleep turns the bias supply off and keeps image memory.
// - Same reset sequence runs at power-on and on software reset.
module dsc_slave #(
  parameter int RST_CYC = dsc_pkg::RST_SEQ_CYC,
  parameter int OP_CYCLES = dsc_pkg::OP_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  input wire logic select_n_i,
  input wire logic reset_pin_n_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic busy_o,
  output logic bias_source_supply_o,
  output dsc_pkg::dsc_update_t update_o
);
  localparam logic [dsc_pkg::TMR_W-1:0] RST_LOAD =
    dsc_pkg::TMR_W'(RST_CYC - 1);
  localparam logic [dsc_pkg::TMR_W-1:0] OP_LOAD =
    dsc_pkg::TMR_W'(OP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [dsc_pkg::PIN_W-1:0] pins_s;
  logic sck_s, cs_s, sdi_s, rst_pin_s;
  logic sck_prev_ff, cs_prev_ff;
  logic sck_rise, sck_fall, cs_rise, cs_fall, sel_act, byte_done;
  logic [7:0] rx_byte;

  dsc_sync #(
    .W(dsc_pkg::PIN_W),
    .RST_VAL(dsc_pkg::PIN_IDLE)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({reset_pin_n_i, select_n_i, serial_clk_i, serial_in_i}),
    .sync_o(pins_s)
  );

  assign rst_pin_s = pins_s[dsc_pkg::PIN_RST_N];
  assign cs_s = pins_s[dsc_pkg::PIN_CS_N];
  assign sck_s = pins_s[dsc_pkg::PIN_SCK];
  assign sdi_s = pins_s[dsc_pkg::PIN_SDI];

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine state
  dsc_pkg::dsc_state_t state_ff, nxt_state;
  logic [dsc_pkg::BIT_CNT_W-1:0] bitcnt_ff, nxt_bitcnt;
  logic [7:0] rx_ff, nxt_rx, tx_ff, nxt_tx;
  logic [7:0] pipe_ff [dsc_pkg::PIPE_DEPTH];
  logic [7:0] nxt_pipe [dsc_pkg::PIPE_DEPTH];
  logic first_ff, nxt_first, oe_ff, nxt_oe;
  dsc_pkg::dsc_status_t status;

  // Edges of the sampled link clock and select
  assign sck_rise = sck_s & ~sck_prev_ff;
  assign sck_fall = ~sck_s & sck_prev_ff;
  assign cs_rise = cs_s & ~cs_prev_ff;
  assign cs_fall = ~cs_s & cs_prev_ff;
  assign sel_act = ~cs_s & (state_ff != dsc_pkg::ST_HOLD);
  assign byte_done = sel_act & sck_fall & (bitcnt_ff == dsc_pkg::LAST_BIT);
  assign rx_byte = {rx_ff[6:0], sdi_s};

  // Next values of the shift engine
  always_comb begin
    nxt_bitcnt = bitcnt_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_pipe = pipe_ff;
    nxt_first = first_ff;
    nxt_oe = sel_act;
    if (!sel_act) begin
      nxt_bitcnt = '0;
    end else begin
      if (sck_fall) begin
        nxt_rx = rx_byte;
        nxt_bitcnt = bitcnt_ff + 3'h1;
      end
      if (sck_rise) begin
        // First rise of each byte loads the oldest status, later ones shift
        nxt_tx = (bitcnt_ff == '0) ? pipe_ff[dsc_pkg::PIPE_DEPTH-1] :
          {tx_ff[6:0], 1'b0};
      end
    end
    if (cs_fall) begin
      nxt_first = 1'b1;
    end
    if (byte_done) begin
      nxt_first = 1'b0;
      nxt_pipe[0] = status;
      for (int i = 1; i < dsc_pkg::PIPE_DEPTH; i++) begin
        nxt_pipe[i] = pipe_ff[i-1];
      end
    end
  end

  // Shift engine registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
      bitcnt_ff <= '0;
      rx_ff <= '0;
      tx_ff <= dsc_pkg::STATUS_RST;
      first_ff <= 1'b0;
      oe_ff <= 1'b0;
      for (int i = 0; i < dsc_pkg::PIPE_DEPTH; i++) begin
        pipe_ff[i] <= dsc_pkg::STATUS_RST;
      end
    end else begin
      sck_prev_ff <= sck_s;
      cs_prev_ff <= cs_s;
      bitcnt_ff <= nxt_bitcnt;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      first_ff <= nxt_first;
      oe_ff <= nxt_oe;
      pipe_ff <= nxt_pipe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command control state
  logic [dsc_pkg::TMR_W-1:0] tmr_ff, nxt_tmr;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [15:0] addr_ff, nxt_addr;
  logic [1:0] argn_ff, nxt_argn;
  logic ended_ff, nxt_ended, bias_ff, nxt_bias;
  dsc_pkg::dsc_update_t upd_ff, nxt_upd;

  // Status: busy while the operation or reset still runs
  always_comb begin
    status = '0;
    status.busy = (state_ff == dsc_pkg::ST_HOLD) |
      (state_ff == dsc_pkg::ST_RSTSEQ) |
      ((state_ff == dsc_pkg::ST_EXEC) & (tmr_ff != '0));
    status.awake = bias_ff;
  end

  // Next values of the command controller
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_argn = argn_ff;
    nxt_ended = ended_ff;
    nxt_bias = bias_ff;
    nxt_upd = upd_ff;
    nxt_upd.strobe = 1'b0;
    unique case (state_ff)
      dsc_pkg::ST_HOLD: begin
        if (rst_pin_s) begin
          nxt_state = dsc_pkg::ST_RSTSEQ;
          nxt_tmr = RST_LOAD;
        end
      end
      dsc_pkg::ST_RSTSEQ: begin
        if (tmr_ff == '0) begin
          nxt_state = dsc_pkg::ST_IDLE;
          nxt_bias = 1'b0;
        end else begin
          nxt_tmr = tmr_ff - 1'b1;
        end
      end
      dsc_pkg::ST_IDLE: begin
        if (byte_done && first_ff) begin
          nxt_state = dsc_pkg::ST_EXEC;
          nxt_cmd = rx_byte;
          nxt_tmr = OP_LOAD;
          nxt_argn = '0;
          nxt_ended = 1'b0;
        end
      end
      dsc_pkg::ST_EXEC: begin
        if (tmr_ff != '0) begin
          nxt_tmr = tmr_ff - 1'b1;
        end
        if (byte_done && argn_ff < 2'(dsc_pkg::ADDR_ARGS)) begin
          nxt_addr = {addr_ff[7:0], rx_byte};
          nxt_argn = argn_ff + 2'h1;
        end
        if (cs_rise) begin
          nxt_ended = 1'b1;
        end
        // Completion waits for the packet to be closed by select
        if (tmr_ff == '0 && ended_ff) begin
          nxt_state = dsc_pkg::ST_IDLE;
          unique case (cmd_ff)
            dsc_pkg::CMD_UPD_WHOLE, dsc_pkg::CMD_UPD_ROWS: begin
              nxt_upd.strobe = 1'b1;
              nxt_upd.whole = (cmd_ff == dsc_pkg::CMD_UPD_WHOLE);
              nxt_upd.addr = addr_ff[dsc_pkg::ADDR_W-1:0];
              nxt_bias = 1'b1;
            end
            dsc_pkg::CMD_SLEEP: begin
              nxt_bias = 1'b0;
            end
            dsc_pkg::CMD_SOFT_RESET: begin
              nxt_state = dsc_pkg::ST_RSTSEQ;
              nxt_tmr = RST_LOAD;
            end
            default: begin
              nxt_bias = bias_ff;
            end
          endcase
        end
      end
    endcase
    // Reset pin low aborts whatever runs
    if (!rst_pin_s) begin
      nxt_state = dsc_pkg::ST_HOLD;
      nxt_upd.strobe = 1'b0;
    end
  end

  // Command controller registers; power-on starts the reset sequence
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= dsc_pkg::ST_RSTSEQ;
      tmr_ff <= RST_LOAD;
      cmd_ff <= '0;
      addr_ff <= '0;
      argn_ff <= '0;
      ended_ff <= 1'b0;
      bias_ff <= 1'b0;
      upd_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      argn_ff <= nxt_argn;
      ended_ff <= nxt_ended;
      bias_ff <= nxt_bias;
      upd_ff <= nxt_upd;
    end
  end

  // Outputs
  assign serial_out_o = tx_ff[7];
  assign serial_out_oe_o = oe_ff;
  assign busy_o = (state_ff != dsc_pkg::ST_IDLE);
  assign bias_source_supply_o = bias_ff;
  assign update_o = upd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_out_release: assert property (cs_s |=> !serial_out_oe_o)
    else $error("serial output driven while deselected");
  a_desel_ignore: assert property (cs_s |=> bitcnt_ff == '0)
    else $error("bit counter moved while deselected");
  a_byte_wrap: assert property (byte_done |=> bitcnt_ff == '0 &&
    rx_ff == $past(rx_byte))
    else $error("byte not closed after eighth bit");
  a_out_msb: assert property (sel_act && sck_rise && bitcnt_ff == '0 |=>
    serial_out_o == $past(pipe_ff[2][7]))
    else $error("status msb not presented first");
  a_pipe_age: assert property (byte_done |=> pipe_ff[2] == $past(pipe_ff[1])
    && pipe_ff[0] == $past(status))
    else $error("status pipeline did not advance");
  a_busy_hold: assert property (!rst_pin_s |=> busy_o)
    else $error("busy low while reset pin held");
  // Only command completion needs the closed packet; reset ends freely
  a_busy_fall: assert property ($fell(busy_o) &&
    $past(state_ff) == dsc_pkg::ST_EXEC |-> cs_s && $past(ended_ff))
    else $error("busy fell before select rose");
  a_upd_source: assert property (update_o.strobe |->
    $past(state_ff) == dsc_pkg::ST_EXEC)
    else $error("update without update command");
  a_sleep_after: assert property (state_ff == dsc_pkg::ST_RSTSEQ &&
    nxt_state == dsc_pkg::ST_IDLE |=> !bias_source_supply_o)
    else $error("bias on after reset sequence");
  a_busy_exec: assert property ($rose(state_ff == dsc_pkg::ST_EXEC) |->
    busy_o [*2])
    else $error("busy not raised for command");
endmodule
`default_nettype wire

/* File: src/dsc_pkg.sv */
// Shared constants and types for the display serial command slave
package dsc_pkg;
  // Timing: system clock and internal sequence lengths
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_SEQ_NS = 100000;
  localparam int RST_SEQ_CYC = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OP_TIME_NS = 10000;
  localparam int OP_CYC = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  // Serial framing
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int PIPE_DEPTH = 3;
  localparam int ADDR_W = 15;
  localparam int ADDR_ARGS = 2;
  // Pin synchroniser layout and idle levels
  localparam int PIN_W = 4;
  localparam int PIN_RST_N = 3;
  localparam int PIN_CS_N = 2;
  localparam int PIN_SCK = 1;
  localparam int PIN_SDI = 0;
  localparam logic [3:0] PIN_IDLE = 4'hc;
  // Command codes (values arbitrary)
  localparam logic [7:0] CMD_UPD_WHOLE = 8'h10;
  localparam logic [7:0] CMD_UPD_ROWS = 8'h11;
  localparam logic [7:0] CMD_SLEEP = 8'h20;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h21;
  // Status byte returned with every byte
  typedef struct packed {
    logic busy;
    logic [5:0] rsvd;
    logic awake;
  } dsc_status_t;
  localparam logic [7:0] STATUS_RST = 8'h80;
  // Display update request to the panel driver
  typedef struct packed {
    logic strobe;
    logic whole;
    logic [ADDR_W-1:0] addr;
  } dsc_update_t;
  // Control states, one-hot
  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_RSTSEQ = 4'h2,
    ST_IDLE = 4'h4,
    ST_EXEC = 4'h8
  } dsc_state_t;
endpackage

/* File: src/dsc_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module dsc_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // One two-stage chain per pin
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        meta_ff[g] <= RST_VAL[g];
        sync_ff[g] <= RST_VAL[g];
      end else begin
        meta_ff[g] <= async_i[g];
        sync_ff[g] <= meta_ff[g];
      end
    end
  end

  assign sync_o = sync_ff;
endmodule
`default_nettype wire

/* File: test/dsc_master_model.sv */
// Link master model that drives the display slave's serial pins
`timescale 1ns/10ps
`default_nettype none
module dsc_master_model (
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic sel_n_o
);
  // Link idles with its clock still and the device deselected
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    sel_n_o = 1'b1;
  end
  // Shifts nb leading bits of a byte, msb first; 200 ns clock period
  task automatic xfer(input logic [7:0] tx, input int nb,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sck_o = 1'b1;
      mosi_o = tx[i];
      #120;
      sck_o = 1'b0;
      rx[i] = miso_i;
      #80;
    end
  endtask
  // Moves select off the system clock grid, then keeps the gap
  task automatic sel(input logic lvl);
    #37;
    sel_n_o = lvl;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_display_spi_command_slave.sv */
// Self-checking bench for the display serial command slave
`timescale 1ns/10ps
`default_nettype none
module tb_display_spi_command_slave;
  localparam int RST_N = 200;
  localparam int OP_N = 100;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rpin_n = 1'b1;
  logic fill_ff = 1'b0;
  logic sck, mosi, sel_n, so, oe, busy, bias;
  wire logic miso;
  dsc_pkg::dsc_update_t upd, last_upd;
  int errors = 0;
  int compares = 0;
  int n_upd = 0;
  int n;
  logic [7:0] r[$];

  ////////////////////////////////////////////////////////////////////
  // Clock and released data line, which toggles rather than holding
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) fill_ff <= ~fill_ff;
  assign miso = oe ? so : fill_ff;
  // Records each display update request
  always @(posedge clk_i) begin
    if (upd.strobe === 1'b1) begin
      last_upd <= upd;
      n_upd <= n_upd + 1;
    end
  end

  dsc_slave #(.RST_CYC(RST_N), .OP_CYCLES(OP_N)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .serial_clk_i(sck),
    .serial_in_i(mosi), .select_n_i(sel_n), .reset_pin_n_i(rpin_n),
    .serial_out_o(so), .serial_out_oe_o(oe), .busy_o(busy),
    .bias_source_supply_o(bias), .update_o(upd));
  dsc_master_model master (
    .miso_i(miso), .sck_o(sck), .mosi_o(mosi), .sel_n_o(sel_n));

  ////////////////////////////////////////////////////////////////////
  // Compare, verdict and bounded wait for busy low
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_idle(input int lim);
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    chk(busy, 1'b0);
  endtask
  // Selects and sends whole bytes, keeping the status bytes
  task automatic packet(input logic [7:0] b[$]);
    logic [7:0] x;
    r = {};
    master.sel(1'b0);
    foreach (b[i]) begin
      master.xfer(b[i], 8, x);
      r.push_back(x);
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    repeat (2) @(posedge clk_i);
    chk(busy, 1'b1);
    chk(oe, 1'b0);
    wait_idle(RST_N + 40);
    chk(n >= RST_N - 20, 1'b1);
    chk(bias, 1'b0);
  endtask
  task automatic t_ignore;
    logic [7:0] x;
    master.xfer(dsc_pkg::CMD_UPD_WHOLE, 8, x);
    repeat (8) @(posedge clk_i);
    chk(busy, 1'b0);
    chk(oe, 1'b0);
  endtask
  task automatic t_whole;
    packet('{dsc_pkg::CMD_UPD_WHOLE, 8'h12, 8'h34, 8'h00, 8'h00,
             8'h00});
    chk(r[4], 8'h80);
    chk(r[5], 8'h00);
    chk(busy, 1'b1);
    chk(n_upd[16:0], 17'h0);
    master.sel(1'b1);
    wait_idle(40);
    chk(oe, 1'b0);
    chk(n_upd[16:0], 17'h1);
    chk(last_upd, {1'b1, 1'b1, 15'h1234});
    chk(bias, 1'b1);
  endtask
  task automatic t_rows;
    packet('{dsc_pkg::CMD_UPD_ROWS, 8'hff, 8'hff});
    master.sel(1'b1);
    wait_idle(OP_N + 40);
    chk(last_upd, {1'b1, 1'b0, 15'h7fff});
  endtask
  task automatic t_partial;
    logic [7:0] x;
    master.sel(1'b0);
    master.xfer(dsc_pkg::CMD_UPD_WHOLE, 4, x);
    master.sel(1'b1);
    repeat (10) @(posedge clk_i);
    chk(busy, 1'b0);
    packet('{dsc_pkg::CMD_SLEEP});
    master.sel(1'b1);
    wait_idle(OP_N + 40);
    chk(bias, 1'b0);
    chk(n_upd[16:0], 17'h2);
  endtask
  task automatic t_pin;
    packet('{dsc_pkg::CMD_UPD_WHOLE, 8'h00, 8'h00});
    @(posedge clk_i);
    rpin_n <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(busy, 1'b1);
    master.sel(1'b1);
    @(posedge clk_i);
    rpin_n <= 1'b1;
    wait_idle(RST_N + 40);
    chk(n >= RST_N, 1'b1);
    chk(n_upd[16:0], 17'h2);
  endtask
  task automatic t_soft;
    packet('{dsc_pkg::CMD_UPD_ROWS, 8'h00, 8'h01});
    master.sel(1'b1);
    wait_idle(OP_N + 40);
    packet('{dsc_pkg::CMD_SOFT_RESET});
    master.sel(1'b1);
    wait_idle(OP_N + RST_N + 40);
    chk(n >= RST_N - 20, 1'b1);
    chk(bias, 1'b0);
    // Second soft reset, waited out by a fixed time instead of busy
    packet('{dsc_pkg::CMD_SOFT_RESET});
    master.sel(1'b1);
    repeat (OP_N + RST_N + 20) @(posedge clk_i);
    chk(busy, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence after 12 cycles of reset
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_ignore();
    t_whole();
    t_rows();
    t_partial();
    t_pin();
    t_soft();
    end_sim();
  end
  // Watchdog: all scenarios take well under 200 us
  initial begin
    #500000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
